// file: mcmd_decoder.sv
// Channel message decoder with tape mode control and AHB-Lite registers
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module mcmd_decoder
    import mcmd_pkg::*;
#(
    parameter longint LEADER_CYCLES = longint'(LEADER_S) * CLK_HZ,
    parameter int DATA_CYCLES   = 4096
)(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        midiByteValid,
    input  wire logic [7:0]  midiByte,
    input  wire logic        writeProtect,
    input  wire logic        tapeLoadFail,
    output logic             noteOn,
    output logic             noteOff,
    output logic [5:0]       noteKey,
    output logic [6:0]       noteVelocity,
    output logic             allNotesOff,
    output logic [6:0]       modAmount,
    output logic             releasePedal,
    output logic [6:0]       activeProgram,
    output logic             programWrite,
    output logic [6:0]       pitchWheel,
    output logic             tapeTone,
    output logic             tapeData,
    output logic             memoryLoad,
    output logic [7:0]       upper_program_display,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] wpSync;
    logic [1:0] failSync;
    logic       wpOn;
    logic       loadBad;

    // Two flops on the switch and fail pins
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wpSync   <= 2'h0;
            failSync <= 2'h0;
        end
        else
        begin
            wpSync   <= {wpSync[0], writeProtect};
            failSync <= {failSync[0], tapeLoadFail};
        end
    end
    assign wpOn    = wpSync[1];
    assign loadBad = failSync[1];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic       wrPend;
    logic [7:0] wrAddr;
    logic       busWr;
    logic       tapeMode;
    logic       tapeCmdSave;
    logic       tapeCmdLoad;
    logic       tapeExit;
    logic       tapeEnter;

    // Capture the address phase of a write
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end
        else if (hready)
        begin
            wrPend <= hsel && htrans[1] && hwrite;
            wrAddr <= haddr[7:0];
        end
    end
    assign busWr     = wrPend;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign tapeEnter   = busWr && wrAddr == REG_CTRL && hwdata[CTRL_TAPE] && !tapeMode;
    assign tapeExit    = busWr && wrAddr == REG_CTRL && !hwdata[CTRL_TAPE] && tapeMode;
    assign tapeCmdSave = busWr && wrAddr == REG_CTRL && hwdata[CTRL_SAVE] && tapeMode;
    assign tapeCmdLoad = busWr && wrAddr == REG_CTRL && hwdata[CTRL_LOAD] && tapeMode;

    // ------------------------------------------------------------
    // Receive settings
    // ------------------------------------------------------------
    logic       softRst;
    logic       pitchEn;
    logic       modEn;
    logic       pedalEn;
    logic       progEn;
    logic       kbdMode;
    logic       omni;
    logic [3:0] rxChannel;
    logic [3:0] txChannel;
    logic       omniSetOn;
    logic       omniSetOff;

    assign softRst = rst || tapeExit;

    // Settings written by software, omni also by controllers
    always_ff @(posedge mclk)
    begin
        if (softRst)
        begin
            omni      <= RST_OMNI;
            rxChannel <= RST_CHANNEL;
            txChannel <= RST_CHANNEL;
            pitchEn   <= RST_ENABLE;
            modEn     <= RST_ENABLE;
            pedalEn   <= RST_ENABLE;
            progEn    <= RST_ENABLE;
            kbdMode   <= RST_KBD_MODE;
        end
        else if (busWr && wrAddr == REG_CTRL)
        begin
            pitchEn   <= hwdata[CTRL_PITCH_EN];
            modEn     <= hwdata[CTRL_MOD_EN];
            pedalEn   <= hwdata[CTRL_PEDAL_EN];
            progEn    <= hwdata[CTRL_PROG_EN];
            kbdMode   <= hwdata[CTRL_KBD_MODE];
            omni      <= hwdata[CTRL_OMNI];
            rxChannel <= hwdata[CTRL_RX_LSB +: 4];
            txChannel <= hwdata[CTRL_TX_LSB +: 4];
        end
        else if (omniSetOn || omniSetOff)
            omni <= omniSetOn;
    end

    // ------------------------------------------------------------
    // Message parser
    // ------------------------------------------------------------
    mcmd_parse_t parseState;
    logic [3:0]  msgType;
    logic [3:0]  msgChan;
    logic [6:0]  data1;
    logic        isStatus;
    logic        chanOk;
    logic        complete;
    logic        twoBytes;

    assign isStatus = midiByte[7];
    assign twoBytes = msgType != MSG_PROGRAM;
    assign chanOk   = omni || msgChan == rxChannel;

    // Track status, running status and data byte count
    always_ff @(posedge mclk)
    begin
        if (softRst)
        begin
            parseState <= MC_WAIT;
            msgType    <= 4'h0;
            msgChan    <= 4'h0;
            data1      <= 7'h00;
        end
        else if (midiByteValid && !tapeMode)
        begin
            if (isStatus)
            begin
                msgType    <= midiByte[7:4];
                msgChan    <= midiByte[3:0];
                parseState <= (midiByte[7:4] == MSG_NOTE_OFF || midiByte[7:4] == MSG_NOTE_ON
                    || midiByte[7:4] == MSG_CTRL || midiByte[7:4] == MSG_PROGRAM
                    || midiByte[7:4] == MSG_PITCH) ? MC_DATA1 : MC_WAIT;
            end
            else
            begin
                unique case (parseState)
                    MC_WAIT:  parseState <= MC_WAIT;
                    MC_DATA1:
                    begin
                        data1      <= midiByte[6:0];
                        parseState <= twoBytes ? MC_DATA2 : MC_DATA1;
                    end
                    MC_DATA2: parseState <= MC_DATA1;
                endcase
            end
        end
    end
    assign complete = midiByteValid && !tapeMode && !isStatus && chanOk
        && ((parseState == MC_DATA2) || (parseState == MC_DATA1 && !twoBytes));

    // ------------------------------------------------------------
    // Decoded actions
    // ------------------------------------------------------------
    logic       isCtrl;
    logic       isNoteOn;
    logic       isNoteOff;
    logic       progChange;
    logic [6:0] next_program;
    logic [6:0] keyFold;
    logic       silence;

    assign isCtrl     = complete && msgType == MSG_CTRL;
    assign omniSetOff = isCtrl && data1 == CTL_OMNI_OFF;
    assign omniSetOn  = isCtrl && data1 == CTL_OMNI_ON;
    assign isNoteOn   = complete && msgType == MSG_NOTE_ON && midiByte[6:0] != 7'h00;
    assign isNoteOff  = complete && (msgType == MSG_NOTE_OFF
        || (msgType == MSG_NOTE_ON && midiByte[6:0] == 7'h00));
    // Data byte of a program change
    assign next_program = (midiByte[6:0] > PROG_LAST)
        ? 7'(midiByte[6:0] - PROG_WRAP) : midiByte[6:0];
    assign progChange = complete && msgType == MSG_PROGRAM && progEn
        && next_program != activeProgram;

    // Fold key number into the 61-key span by octaves
    always_comb
    begin
        keyFold = data1;
        if (data1 < KEY_LOW)
            keyFold = 7'(KEY_LOW + (KEY_OCTAVE - (KEY_LOW - data1) % KEY_OCTAVE) % KEY_OCTAVE);
        else if (data1 > KEY_HIGH)
            keyFold = 7'(KEY_HIGH - (KEY_OCTAVE - (data1 - KEY_HIGH) % KEY_OCTAVE)
                % KEY_OCTAVE);
    end

    // All-notes-off sources
    assign silence = softRst || tapeEnter || progChange || omniSetOn || omniSetOff
        || (busWr && wrAddr == REG_CTRL && hwdata[CTRL_OMNI] != omni)
        || (isCtrl && data1 == CTL_ALL_OFF);

    // Note event outputs, one-cycle pulses
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            noteOn       <= 1'b0;
            noteOff      <= 1'b0;
            noteKey      <= 6'h00;
            noteVelocity <= 7'h00;
            allNotesOff  <= 1'b1;
        end
        else
        begin
            noteOn      <= isNoteOn;
            noteOff     <= isNoteOff;
            allNotesOff <= silence;
            if (isNoteOn || isNoteOff)
            begin
                noteKey      <= 6'(keyFold - KEY_LOW);
                noteVelocity <= midiByte[6:0];
            end
        end
    end

    // Controller, program and wheel values
    always_ff @(posedge mclk)
    begin
        if (softRst)
        begin
            modAmount    <= 7'h00;
            releasePedal <= 1'b0;
            activeProgram <= RST_PROGRAM;
            programWrite <= 1'b0;
            pitchWheel   <= RST_PITCH;
        end
        else
        begin
            programWrite <= progChange;
            if (isCtrl && modEn && data1 == CTL_MOD_WHEEL)
                modAmount <= midiByte[6:0];
            if (isCtrl && pedalEn && data1 == CTL_RELEASE)
                releasePedal <= midiByte[6:0] == PEDAL_PRESSED;
            if (progChange)
                activeProgram <= next_program;
            if (complete && pitchEn && msgType == MSG_PITCH)
                pitchWheel <= midiByte[6:0];
        end
    end

    // ------------------------------------------------------------
    // Tape mode sequencing
    // ------------------------------------------------------------
    mcmd_tape_t  tapeState;
    logic        tapeIsLoad;
    logic [31:0] tapeCount;
    logic        loadErr;

    // Tape mode entry and exit
    always_ff @(posedge mclk)
    begin
        if (rst)
            tapeMode <= 1'b0;
        else if (tapeEnter || tapeExit)
            tapeMode <= tapeEnter;
    end

    // Save and load sequence
    always_ff @(posedge mclk)
    begin
        if (softRst || tapeEnter)
        begin
            tapeState             <= MC_TIDLE;
            tapeIsLoad            <= 1'b0;
            tapeCount             <= 32'h0;
            loadErr               <= 1'b0;
            upper_program_display <= 8'h00;
        end
        else
        begin
            unique case (tapeState)
                MC_TIDLE:
                begin
                    tapeCount <= 32'h0;
                    if (tapeCmdSave)
                        tapeState <= MC_TLEADER;
                    else if (tapeCmdLoad && !wpOn)
                    begin
                        tapeIsLoad <= 1'b1;
                        loadErr    <= 1'b0;
                        tapeState  <= MC_TDATA;
                    end
                    else if (tapeCmdLoad)
                        upper_program_display <= TAPE_PROTECTED;
                end
                MC_TLEADER:
                begin
                    tapeCount <= tapeCount + 32'h1;
                    if (tapeCount == 32'(LEADER_CYCLES - 1))
                    begin
                        tapeCount <= 32'h0;
                        tapeState <= MC_TDATA;
                    end
                end
                MC_TDATA:
                begin
                    tapeCount <= tapeCount + 32'h1;
                    if (tapeIsLoad && loadBad)
                        loadErr <= 1'b1;
                    if (tapeCount == 32'(DATA_CYCLES - 1))
                        tapeState <= MC_TDONE;
                end
                MC_TDONE:
                begin
                    upper_program_display <= loadErr ? 8'h01 : TAPE_OK;
                    tapeIsLoad            <= 1'b0;
                    tapeState             <= MC_TIDLE;
                end
            endcase
        end
    end
    assign tapeTone   = tapeState == MC_TLEADER;
    assign tapeData   = tapeState == MC_TDATA && !tapeIsLoad;
    assign memoryLoad = tapeState == MC_TDATA && tapeIsLoad;

    // ------------------------------------------------------------
    // Register read data
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            hrdata <= 32'h0;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            unique case (haddr[7:0])
                REG_CTRL:   hrdata <= {11'h0, loadErr, tapeState == MC_TIDLE,
                    tapeState == MC_TDATA && tapeIsLoad, tapeState != MC_TIDLE, tapeMode,
                    txChannel, rxChannel, 2'h0, omni, kbdMode, progEn, pedalEn, modEn,
                    pitchEn};
                REG_STATUS: hrdata <= {24'h0, upper_program_display};
                REG_PARAMS: hrdata <= {1'b0, pitchWheel, 1'b0, activeProgram, 8'h0,
                    releasePedal, modAmount};
                REG_NOTE:   hrdata <= {16'h0, 1'b0, noteVelocity, 2'h0, noteKey};
                REG_SEND:   hrdata <= {28'h0, txChannel};
                default:    hrdata <= 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: mcmd_decoder_properties.sv
// Checker of port behaviour of the channel message decoder
`timescale 1ns/1ps
`default_nettype none
module mcmd_decoder_checker (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       midiByteValid,
    input wire logic       noteOn,
    input wire logic       noteOff,
    input wire logic [5:0] noteKey,
    input wire logic [6:0] noteVelocity,
    input wire logic       allNotesOff,
    input wire logic [6:0] activeProgram,
    input wire logic       programWrite,
    input wire logic       tapeTone,
    input wire logic       tapeData
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Note events
    // ----------------------------------------
    a_note_after_byte: assert property ((noteOn || noteOff) |-> $past(midiByteValid))
        else $error("note event without a byte just before");
    a_note_single_pulse: assert property ((noteOn || noteOff) |-> !(noteOn && noteOff) ##1 !(noteOn || noteOff))
        else $error("note event not a single clean pulse");
    a_key_in_span: assert property ((noteOn || noteOff) |-> noteKey <= 6'h3c)
        else $error("key outside the keyboard");
    a_zero_vel_off: assert property (noteOn |-> noteVelocity != 7'h00)
        else $error("note on with zero velocity");

    // ----------------------------------------
    // Silencing, programs and tape
    // ----------------------------------------
    a_power_up_silence: assert property ($fell(rst) |-> allNotesOff)
        else $error("no all notes off after reset");
    a_program_silence: assert property (programWrite |-> ##[0:2] allNotesOff)
        else $error("program change without all notes off");
    a_program_range: assert property (activeProgram <= 7'h62)
        else $error("program number beyond the last program");
    a_tape_one_phase: assert property (!(tapeTone && tapeData))
        else $error("leader tone and data together");
    a_tone_then_data: assert property ($fell(tapeTone) |-> ##[0:2] tapeData)
        else $error("leader not followed by data");

    c_note: cover property (noteOn);
    c_program: cover property (programWrite);
    c_save: cover property (tapeTone ##[1:20] tapeData);
endmodule

bind mcmd_decoder mcmd_decoder_checker i_mcmd_decoder_checker (
    .mclk(mclk), .rst(rst), .midiByteValid(midiByteValid), .noteOn(noteOn),
    .noteOff(noteOff), .noteKey(noteKey), .noteVelocity(noteVelocity),
    .allNotesOff(allNotesOff), .activeProgram(activeProgram), .programWrite(programWrite),
    .tapeTone(tapeTone), .tapeData(tapeData)
);
`default_nettype wire

// file: mcmd_midi_source.sv
// Model of a MIDI transmitter feeding bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module mcmd_midi_source (
    input  wire logic      mclk,
    output var logic       byteValid,
    output var logic [7:0] byteOut
);
    // Idle line at time zero
    initial
    begin
        byteValid = 1'b0;
        byteOut   = 8'h00;
    end

    // One byte, strobe for one clock, then the stale byte is inverted
    task automatic put(input logic [7:0] b, input int gap);
        @(posedge mclk);
        byteValid <= 1'b1;
        byteOut   <= b;
        @(posedge mclk);
        byteValid <= 1'b0;
        byteOut   <= ~b;
        repeat (gap) @(posedge mclk);
    endtask

    // Status first, then data in order; pitch low byte goes first
    task automatic msg(input logic [7:0] st, input logic [7:0] d1, input logic [7:0] d2,
                       input int n, input int gap);
        put(st, gap);
        put(d1, (n == 2) ? gap : 0);
        if (n == 2)
            put(d2, 0);
    endtask
endmodule
`default_nettype wire

// file: mcmd_pkg.sv
// Package of constants and types for the channel message decoder
package mcmd_pkg;
    // Status byte message types (high nibble)
    localparam logic [3:0] MSG_NOTE_OFF   = 4'h8;
    localparam logic [3:0] MSG_NOTE_ON    = 4'h9;
    localparam logic [3:0] MSG_CTRL       = 4'hb;
    localparam logic [3:0] MSG_PROGRAM    = 4'hc;
    localparam logic [3:0] MSG_PITCH      = 4'he;
    // Controller numbers
    localparam logic [6:0] CTL_MOD_WHEEL  = 7'h01;
    localparam logic [6:0] CTL_RELEASE    = 7'h40;
    localparam logic [6:0] CTL_ALL_OFF    = 7'h7b;
    localparam logic [6:0] CTL_OMNI_OFF   = 7'h7c;
    localparam logic [6:0] CTL_OMNI_ON    = 7'h7d;
    // Key span, program span and pedal pressed value
    localparam logic [6:0] KEY_LOW        = 7'h24;
    localparam logic [6:0] KEY_HIGH       = 7'h60;
    localparam logic [6:0] KEY_OCTAVE     = 7'h0c;
    localparam logic [6:0] PROG_LAST      = 7'h62;
    localparam logic [6:0] PROG_WRAP      = 7'h63;
    localparam logic [6:0] PEDAL_PRESSED  = 7'h7f;
    // Power-up settings
    localparam logic       RST_OMNI       = 1'b1;
    localparam logic [3:0] RST_CHANNEL    = 4'h0;
    localparam logic       RST_ENABLE     = 1'b0;
    localparam logic       RST_KBD_MODE   = 1'b0;
    localparam logic [6:0] RST_PROGRAM    = 7'h00;
    localparam logic [6:0] RST_PITCH      = 7'h40;
    // Tape leader time, clock rate and status codes
    localparam int         LEADER_S       = 25;
    localparam int         CLK_HZ         = 125000000;
    localparam logic [7:0] TAPE_OK        = 8'h00;
    localparam logic [7:0] TAPE_PROTECTED = 8'h02;
    // AHB-Lite register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_PARAMS     = 8'h08;
    localparam logic [7:0] REG_NOTE       = 8'h0c;
    localparam logic [7:0] REG_SEND       = 8'h10;
    // Control register fields
    localparam int         CTRL_PITCH_EN  = 0;
    localparam int         CTRL_MOD_EN    = 1;
    localparam int         CTRL_PEDAL_EN  = 2;
    localparam int         CTRL_PROG_EN   = 3;
    localparam int         CTRL_KBD_MODE  = 4;
    localparam int         CTRL_OMNI      = 5;
    localparam int         CTRL_RX_LSB    = 8;
    localparam int         CTRL_TX_LSB    = 12;
    localparam int         CTRL_TAPE      = 16;
    localparam int         CTRL_SAVE      = 17;
    localparam int         CTRL_LOAD      = 18;
    localparam int         CTRL_LOAD_ERR  = 19;
    localparam int         CTRL_LOAD_DONE = 20;
    // Parser and tape states
    typedef enum logic [1:0] {MC_WAIT, MC_DATA1, MC_DATA2} mcmd_parse_t;
    typedef enum logic [1:0] {MC_TIDLE, MC_TLEADER, MC_TDATA, MC_TDONE} mcmd_tape_t;
endpackage

// file: testbench.sv
// Self-checking bench for the channel message decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin nFail++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module testbench
    import mcmd_pkg::*;
;
    localparam logic [7:0] CORNER [4] = '{8'h00, 8'h7f, 8'h24, 8'h60};
    localparam logic [7:0] PROGS [4]  = '{8'h62, 8'h63, 8'h7f, 8'h00};
    localparam logic [7:0] CTLS [6]   = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h40, 8'h40};
    localparam logic [7:0] CVALS [6]  = '{8'h7f, 8'h00, 8'h00, 8'h33, 8'h7f, 8'h00};
    logic        mclk = 1'b0, rst = 1'b1, writeProtect = 1'b0, tapeLoadFail = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
    logic        midiByteValid, noteOn, noteOff, allNotesOff, releasePedal, programWrite;
    logic        tapeTone, tapeData, memoryLoad, hreadyout, hresp;
    logic [7:0]  midiByte, upper_program_display;
    logic [5:0]  noteKey;
    logic [6:0]  noteVelocity, modAmount, activeProgram, pitchWheel;
    int          nFail = 0, totalChecks = 0;

    // ----------------------------------------
    // Clock, design and transmitter
    // ----------------------------------------
    initial
    begin
        forever #4 mclk = ~mclk;
    end

    mcmd_decoder #(.LEADER_CYCLES(10), .DATA_CYCLES(8)) i_mcmd_decoder (
        .mclk(mclk), .rst(rst), .midiByteValid(midiByteValid), .midiByte(midiByte),
        .writeProtect(writeProtect), .tapeLoadFail(tapeLoadFail), .noteOn(noteOn),
        .noteOff(noteOff), .noteKey(noteKey), .noteVelocity(noteVelocity),
        .allNotesOff(allNotesOff), .modAmount(modAmount), .releasePedal(releasePedal),
        .activeProgram(activeProgram), .programWrite(programWrite), .pitchWheel(pitchWheel),
        .tapeTone(tapeTone), .tapeData(tapeData), .memoryLoad(memoryLoad),
        .upper_program_display(upper_program_display), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    mcmd_midi_source i_mcmd_midi_source (
        .mclk(mclk), .byteValid(midiByteValid), .byteOut(midiByte));

    // ----------------------------------------
    // Expected values and bus tasks
    // ----------------------------------------
    function automatic logic [5:0] map_key(input logic [6:0] k);
        logic [7:0] x;
        x = {1'b0, k};
        while (x < 8'h24) x = x + 8'h0c;
        while (x > 8'h60) x = x - 8'h0c;
        return 6'(x - 8'h24);
    endfunction

    function automatic logic [6:0] map_prog(input logic [6:0] p);
        return (p > 7'h62) ? p - 7'h63 : p;
    endfunction

    // Single word transfer; waits on ready in both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask

    task automatic snd(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b, input int n);
        i_mcmd_midi_source.msg(s, a, b, n, $urandom % 3);
    endtask

    // Looks for a pulse over four cycles
    task automatic pulse(input int idx, output logic hit);
        logic [3:0] p;
        hit = 1'b0;
        repeat (4)
        begin
            #1;
            p = {programWrite, allNotesOff, noteOff, noteOn};
            hit = hit | p[idx];
            @(posedge mclk);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog, well beyond the roughly one thousand cycles the tests need
    initial
    begin
        repeat (30000) @(posedge mclk);
        nFail++;
        report_and_stop();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] v, pv;
        logic [6:0] em;
        logic       ep, h;
        int         tn, td, ml;
        void'($urandom(32'hd1ea));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        // Disabled features are ignored after power-up
        snd(8'hb0, 8'h01, 8'h55, 2);
        snd(8'hc0, 8'h10, 8'h00, 1);
        snd(8'he0, 8'h00, 8'h11, 2);
        ahb(1'b0, REG_CTRL, 32'h0);
        `CHK("ctrl", 32'h20, rdata & 32'hffff)
        ahb(1'b0, REG_PARAMS, 32'h0);
        `CHK("params", 32'h40000000, rdata)
        ahb(1'b0, REG_SEND, 32'h0);
        `CHK("send channel", 32'h0, rdata)
        ahb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, rdata)
        `CHK("response", 1'b0, hresp)
        // Notes on all channels, corner keys first
        for (int i = 0; i < 32; i++)
        begin
            pv = (i < 4) ? CORNER[i] : 8'($urandom % 128);
            v = (i % 5 == 1) ? 8'h00 : 8'($urandom % 128);
            snd((i % 3 == 0 ? 8'h80 : 8'h90) | 8'(i % 16), pv, v, 2);
            h = (i % 3 != 0) && (v != 8'h00);
            pulse(h ? 0 : 1, h);
            `CHK("note event", 1'b1, h)
            `CHK("key", map_key(pv[6:0]), noteKey)
            `CHK("velocity", v[6:0], noteVelocity)
        end
        // Controllers once enabled
        ahb(1'b1, REG_CTRL, 32'h2f);
        em = 7'h00;
        ep = 1'b0;
        for (int j = 0; j < 6; j++)
        begin
            v = (j == 2) ? 8'($urandom % 128) : CVALS[j];
            snd(8'hb0 | 8'($urandom % 16), CTLS[j], v, 2);
            em = (CTLS[j] == 8'h01) ? v[6:0] : em;
            ep = (CTLS[j] == 8'h40) ? (v == 8'h7f) : ep;
            repeat (3) @(posedge mclk);
            `CHK("controller", {ep, em}, {releasePedal, modAmount})
        end
        pv = 8'($urandom % 128);
        snd(8'he3, 8'h7f, pv, 2);
        repeat (3) @(posedge mclk);
        `CHK("bend", pv[6:0], pitchWheel)
        // Program span ends, memory protected
        writeProtect <= 1'b1;
        for (int j = 0; j < 4; j++)
        begin
            snd(8'hc0, PROGS[j], 8'h00, 1);
            pulse(3, h);
            `CHK("program write", 1'b1, h)
            `CHK("program", map_prog(PROGS[j][6:0]), activeProgram)
        end
        // Omni controllers and channel filter
        snd(8'hb0, 8'h7b, 8'h00, 2);
        pulse(2, h);
        `CHK("all off", 1'b1, h)
        snd(8'hb0, 8'h7c, 8'h00, 2);
        pulse(2, h);
        `CHK("omni off", 1'b1, h)
        snd(8'h95, 8'h30, 8'h40, 2);
        pulse(0, h);
        `CHK("other channel", 1'b0, h)
        snd(8'h90, 8'h30, 8'h40, 2);
        pulse(0, h);
        `CHK("own channel", 1'b1, h)
        snd(8'hb0, 8'h7d, 8'h00, 2);
        pulse(2, h);
        `CHK("omni on", 1'b1, h)
        ahb(1'b0, REG_CTRL, 32'h0);
        `CHK("omni", 1'b1, rdata[CTRL_OMNI])
        // Tape entry and save
        ahb(1'b1, REG_CTRL, 32'h1002f);
        pulse(2, h);
        `CHK("tape silence", 1'b1, h)
        ahb(1'b1, REG_CTRL, 32'h3002f);
        tn = 0;
        td = 0;
        repeat (80)
        begin
            @(posedge mclk);
            #1;
            tn += tapeTone;
            td += tapeData;
        end
        `CHK("leader", 1'b1, tn >= 9 && tn <= 11)
        `CHK("data", 1'b1, td >= 7 && td <= 9)
        ahb(1'b0, REG_STATUS, 32'h0);
        `CHK("save done", 8'h00, rdata[7:0])
        // Loads: protected, failing, good
        for (int j = 0; j < 3; j++)
        begin
            writeProtect <= (j == 0);
            tapeLoadFail <= (j == 1);
            repeat (4) @(posedge mclk);
            ahb(1'b1, REG_CTRL, 32'h5002f);
            ml = 0;
            repeat (60)
            begin
                @(posedge mclk);
                #1;
                ml += memoryLoad;
            end
            ahb(1'b0, REG_STATUS, 32'h0);
            `CHK("load code", (j == 0) ? 8'h02 : 8'(j == 1), rdata[7:0])
            `CHK("memory write", j != 0, ml > 0)
        end
        // Leaving tape mode restores power-up settings
        ahb(1'b1, REG_CTRL, 32'h2f);
        ahb(1'b0, REG_CTRL, 32'h0);
        `CHK("soft reset ctrl", 32'h20, rdata & 32'hffff)
        ahb(1'b0, REG_PARAMS, 32'h0);
        `CHK("soft reset params", 32'h40000000, rdata)
        report_and_stop();
    end
endmodule
`default_nettype wire
